//--- verilog/usc_defines.svh
// register map, field positions, reset values and timing counts of the serial block
`ifndef USC_DEFINES_SVH
`define USC_DEFINES_SVH
`define USC_OFF_STATUS 8'h00
`define USC_OFF_CTL1 8'h04
`define USC_OFF_CTL2 8'h08
`define USC_OFF_DATA 8'h0c
`define USC_OFF_BAUD 8'h10
`define USC_OFF_MODE 8'h14
`define USC_ST_PERR 7
`define USC_ST_NOISE 6
`define USC_ST_FERR 5
`define USC_ST_OVR 4
`define USC_ST_RIDLE 3
`define USC_ST_RAVAIL 2
`define USC_ST_TIDLE 1
`define USC_ST_TEMPTY 0
`define USC_C1_EN 7
`define USC_C1_LEN9 6
`define USC_C1_PAREN 5
`define USC_C1_PARODD 4
`define USC_C1_STOP2 3
`define USC_C1_BRK 2
`define USC_C1_RX9 1
`define USC_C1_TX9 0
`define USC_C2_TXEN 7
`define USC_C2_RXEN 6
`define USC_C2_HISPD 5
`define USC_C2_RIE 2
`define USC_MODE_SEL 0
`define USC_RST_CTL1 8'h00
`define USC_RST_CTL2 8'h00
`define USC_RST_BAUD 8'h00
`define USC_RST_MODE 8'h00
`define USC_OSR_LAST 4'hf
`define USC_SMP_A 4'h7
`define USC_SMP_C 4'h9
`define USC_LOW_PRE_LAST 2'h3
`define USC_BRK_LAST 4'hc
`endif

//--- verilog/usc_pkg.sv
// types shared by the serial block
package usc_pkg;
	typedef enum logic [2:0] {
		USC_TX_IDLE = 3'h0,
		USC_TX_START = 3'h1,
		USC_TX_DATA = 3'h3,
		USC_TX_PAR = 3'h2,
		USC_TX_STOP = 3'h6,
		USC_TX_BRK = 3'h7
	} usc_tx_e;
	typedef enum logic [2:0] {
		USC_RX_IDLE = 3'h0,
		USC_RX_START = 3'h1,
		USC_RX_DATA = 3'h3,
		USC_RX_PAR = 3'h2,
		USC_RX_STOP = 3'h6
	} usc_rx_e;
endpackage : usc_pkg

//--- verilog/usc_uart.sv
// asynchronous serial transceiver with status, control and shared data register on ahb-lite
//
// Summary of operation
// - noise flag set with receive-available, never on an overrun.
// - status read then data access clears noise, framing and overrun flags.
// - framing flag follows the stop bit of the current character.
// - overflow sets overrun and blocks transfers into data register while set.
// - receiver-idle low from start detection until stop bit ends.
// - word transfer sets available, error flags and interrupt event same cycle.
// - available clears after seen status read, data read, no more data.
// - transmitter-idle set when empty and nothing sending; line high then.
// - transmitter-idle clears on seen status read then data write.
// - transmit-empty set on shift load, cleared by seen read then write.
// - transmit-empty set whenever transmitter enable, block enable or mode is clear.
// - pins float with block disabled or mode clear, else follow tx and rx enables.
// - disable aborts, clears tx and rx enables, break, flags; sets idle/empty flags.
// - eight or nine bit words; ninth bit write-only out, read-only in.
// - parity added and checked only when enabled; odd when type is one.
// - one stop bit or two stop bits by stop select.
// - break waits for buffered data then holds line low 13 bits minimum.
// - transmitter drives line only with its enable, block enable and mode.
// - control registers come up all zero.
// - words shift least significant bit first at baud rate.
// - free 8-bit divider, rate clock over 64(N+1) or 16(N+1).
// - parity mismatch on a received word sets parity error flag.
`include "usc_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module usc_uart
	import usc_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// ahb-lite slave
	input wire logic hsel_i,
	input wire logic [ADDR_W-1:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// serial pins
	input wire logic rx_i,
	output logic tx_o,
	output logic tx_oe_o,
	output logic rx_claim_o,
	// receive event
	output logic rx_event_o
);
	generate
		if (ADDR_W < 8)
		begin : g_chk
			$error("ADDR_W must be at least 8");
		end
	endgenerate

	logic rd_pend, wr_pend;
	logic [7:0] addr_q;
	logic [7:0] ctl1, ctl2, baud, mode;
	logic [7:0] next_ctl1, next_ctl2;
	logic [7:0] rx_data, rd_val, wdata;
	logic rx_ninth, rx_avail, ovr, noise, ferr, perr, ridle, tidle, tempty;
	logic seen, snap_avail, snap_tidle, snap_tempty;
	logic active, tx_run, rx_run, ov_tick;
	logic [7:0] div_cnt;
	logic [1:0] pre_cnt;
	usc_tx_e tx_state;
	usc_rx_e rx_state;
	logic [8:0] tx_shift, hold_data;
	logic hold_full, tx_line, tx_par, tx_load;
	logic [3:0] tx_os, tx_cnt;
	logic [3:0] rx_os, rx_cnt;
	logic [8:0] rx_shift;
	logic [2:0] rx_smp;
	logic rx_noise_acc, rx_par_acc, rx_done, rx_fe, rx_pe, rx_nz;
	logic maj, smp_noise, transfer, data_rd, data_wr;

	// bus strobes come from the latched address phase
	assign wdata = hwdata_i[7:0];
	assign data_rd = rd_pend && (addr_q == `USC_OFF_DATA);
	assign data_wr = wr_pend && (addr_q == `USC_OFF_DATA);
	assign active = ctl1[`USC_C1_EN] && mode[`USC_MODE_SEL];
	assign tx_run = active && ctl2[`USC_C2_TXEN];
	assign rx_run = active && ctl2[`USC_C2_RXEN];

	// reads take one wait state so a write just before is already visible
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			rd_pend <= 1'b0;
			wr_pend <= 1'b0;
			addr_q <= 8'h00;
			hrdata_o <= 32'h0000_0000;
			hreadyout_o <= 1'b1;
			hresp_o <= 1'b0;
		end
		else
		begin
			wr_pend <= hsel_i && htrans_i[1] && hready_i && hwrite_i;
			rd_pend <= hsel_i && htrans_i[1] && hready_i && !hwrite_i;
			if (hsel_i && htrans_i[1] && hready_i)
				addr_q <= haddr_i[7:0];
			if (rd_pend)
			begin
				hrdata_o <= {24'h00_0000, rd_val};
				hreadyout_o <= 1'b1;
			end
			else if (hsel_i && htrans_i[1] && hready_i && !hwrite_i)
				hreadyout_o <= 1'b0;
		end
	end

	// read multiplexer; unmapped offsets read zero
	always_comb
	begin
		case (addr_q)
			`USC_OFF_STATUS: rd_val = {perr, noise, ferr, ovr, ridle, rx_avail, tidle, tempty};
			`USC_OFF_CTL1: rd_val = {ctl1[7:2], rx_ninth, 1'b0};
			`USC_OFF_CTL2: rd_val = ctl2;
			`USC_OFF_DATA: rd_val = rx_data;
			`USC_OFF_BAUD: rd_val = baud;
			`USC_OFF_MODE: rd_val = mode;
			default: rd_val = 8'h00;
		endcase
	end

	// control writes, then the disable side effects on top
	always_comb
	begin
		next_ctl1 = ctl1;
		next_ctl2 = ctl2;
		if (wr_pend && addr_q == `USC_OFF_CTL1)
			next_ctl1 = {wdata[7:2], 1'b0, wdata[0]};
		if (wr_pend && addr_q == `USC_OFF_CTL2)
			next_ctl2 = wdata;
		if (!next_ctl1[`USC_C1_EN])
		begin
			next_ctl1[`USC_C1_BRK] = 1'b0;
			next_ctl2[`USC_C2_TXEN] = 1'b0;
			next_ctl2[`USC_C2_RXEN] = 1'b0;
		end
	end

	// configuration registers
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			ctl1 <= `USC_RST_CTL1;
			ctl2 <= `USC_RST_CTL2;
			baud <= `USC_RST_BAUD;
			mode <= `USC_RST_MODE;
		end
		else
		begin
			ctl1 <= next_ctl1;
			ctl2 <= next_ctl2;
			if (wr_pend && addr_q == `USC_OFF_BAUD)
				baud <= wdata;
			if (wr_pend && addr_q == `USC_OFF_MODE)
				mode <= {7'h00, wdata[0]};
		end
	end

	// baud divider gives a 16x oversampling tick; low speed adds a divide by four
	assign ov_tick = (div_cnt == baud) && (ctl2[`USC_C2_HISPD] || pre_cnt == `USC_LOW_PRE_LAST);
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i || !active)
		begin
			div_cnt <= 8'h00;
			pre_cnt <= 2'h0;
		end
		else if (div_cnt == baud)
		begin
			div_cnt <= 8'h00;
			pre_cnt <= pre_cnt + 2'h1;
		end
		else
			div_cnt <= div_cnt + 8'h01;
	end

	// transmitter; leaving enable aborts the frame and drops the holding word
	assign tx_load = (tx_state == USC_TX_IDLE) && hold_full && tx_run;
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i || !tx_run)
		begin
			tx_state <= USC_TX_IDLE;
			tx_line <= 1'b1;
			hold_full <= 1'b0;
			hold_data <= 9'h000;
			tx_shift <= 9'h000;
			tx_par <= 1'b0;
			tx_os <= 4'h0;
			tx_cnt <= 4'h0;
		end
		else
		begin
			if (data_wr)
			begin
				hold_data <= {ctl1[`USC_C1_TX9], wdata};
				hold_full <= 1'b1;
			end
			if (ov_tick)
				tx_os <= tx_os + 4'h1;
			case (tx_state)
				USC_TX_IDLE:
				begin
					tx_line <= 1'b1;
					tx_os <= 4'h0;
					tx_cnt <= 4'h0;
					if (hold_full)
					begin
						tx_shift <= hold_data;
						tx_par <= ^(ctl1[`USC_C1_LEN9] ? hold_data : {1'b0, hold_data[7:0]}) ^ ctl1[`USC_C1_PARODD];
						hold_full <= data_wr;
						tx_line <= 1'b0;
						tx_state <= USC_TX_START;
					end
					else if (ctl1[`USC_C1_BRK])
					begin
						tx_line <= 1'b0;
						tx_state <= USC_TX_BRK;
					end
				end
				USC_TX_START:
					if (ov_tick && tx_os == `USC_OSR_LAST)
					begin
						tx_line <= tx_shift[0];
						tx_state <= USC_TX_DATA;
					end
				USC_TX_DATA:
					if (ov_tick && tx_os == `USC_OSR_LAST)
					begin
						tx_shift <= {1'b0, tx_shift[8:1]};
						tx_cnt <= tx_cnt + 4'h1;
						if (tx_cnt == (ctl1[`USC_C1_LEN9] ? 4'h8 : 4'h7))
						begin
							tx_cnt <= 4'h0;
							tx_line <= ctl1[`USC_C1_PAREN] ? tx_par : 1'b1;
							tx_state <= ctl1[`USC_C1_PAREN] ? USC_TX_PAR : USC_TX_STOP;
						end
						else
							tx_line <= tx_shift[1];
					end
				USC_TX_PAR:
					if (ov_tick && tx_os == `USC_OSR_LAST)
					begin
						tx_line <= 1'b1;
						tx_state <= USC_TX_STOP;
					end
				USC_TX_STOP:
					if (ov_tick && tx_os == `USC_OSR_LAST)
					begin
						tx_cnt <= 4'h1;
						if (!ctl1[`USC_C1_STOP2] || tx_cnt != 4'h0)
							tx_state <= USC_TX_IDLE;
					end
				USC_TX_BRK:
					if (ov_tick && tx_os == `USC_OSR_LAST)
					begin
						if (tx_cnt != `USC_BRK_LAST)
							tx_cnt <= tx_cnt + 4'h1;
						else if (!ctl1[`USC_C1_BRK])
						begin
							tx_line <= 1'b1;
							tx_state <= USC_TX_IDLE;
						end
					end
				default: tx_state <= USC_TX_IDLE;
			endcase
		end
	end

	// centre samples 7..9 voted; any disagreement counts as noise
	assign maj = (rx_smp[0] & rx_smp[1]) | (rx_smp[1] & rx_smp[2]) | (rx_smp[0] & rx_smp[2]);
	assign smp_noise = !(&rx_smp) && (|rx_smp);

	// receiver; a start that is high at its centre is taken as a glitch
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i || !rx_run)
		begin
			rx_state <= USC_RX_IDLE;
			rx_os <= 4'h0;
			rx_cnt <= 4'h0;
			rx_shift <= 9'h000;
			rx_smp <= 3'h7;
			rx_noise_acc <= 1'b0;
			rx_par_acc <= 1'b0;
			rx_done <= 1'b0;
			rx_fe <= 1'b0;
			rx_pe <= 1'b0;
			rx_nz <= 1'b0;
		end
		else
		begin
			rx_done <= 1'b0;
			if (ov_tick)
				rx_os <= rx_os + 4'h1;
			if (ov_tick && rx_os >= `USC_SMP_A && rx_os <= `USC_SMP_C)
				rx_smp <= {rx_smp[1:0], rx_i};
			case (rx_state)
				USC_RX_IDLE:
				begin
					rx_os <= 4'h0;
					rx_cnt <= 4'h0;
					rx_noise_acc <= 1'b0;
					if (!rx_i)
						rx_state <= USC_RX_START;
				end
				USC_RX_START:
					if (ov_tick && rx_os == `USC_OSR_LAST)
					begin
						rx_noise_acc <= smp_noise;
						rx_par_acc <= ctl1[`USC_C1_PARODD];
						rx_state <= maj ? USC_RX_IDLE : USC_RX_DATA;
					end
				USC_RX_DATA:
					if (ov_tick && rx_os == `USC_OSR_LAST)
					begin
						rx_noise_acc <= rx_noise_acc | smp_noise;
						rx_par_acc <= rx_par_acc ^ maj;
						rx_cnt <= rx_cnt + 4'h1;
						if (ctl1[`USC_C1_LEN9])
							rx_shift <= {maj, rx_shift[8:1]};
						else
							rx_shift <= {1'b0, maj, rx_shift[7:1]};
						if (rx_cnt == (ctl1[`USC_C1_LEN9] ? 4'h8 : 4'h7))
							rx_state <= ctl1[`USC_C1_PAREN] ? USC_RX_PAR : USC_RX_STOP;
					end
				USC_RX_PAR:
					if (ov_tick && rx_os == `USC_OSR_LAST)
					begin
						rx_noise_acc <= rx_noise_acc | smp_noise;
						rx_par_acc <= rx_par_acc ^ maj;
						rx_state <= USC_RX_STOP;
					end
				USC_RX_STOP:
					if (ov_tick && rx_os == `USC_OSR_LAST)
					begin
						rx_done <= 1'b1;
						rx_fe <= !maj;
						rx_pe <= ctl1[`USC_C1_PAREN] && rx_par_acc;
						rx_nz <= rx_noise_acc | smp_noise;
						rx_state <= USC_RX_IDLE;
					end
				default: rx_state <= USC_RX_IDLE;
			endcase
		end
	end

	// a finished word moves in only when the data register and overrun are clear
	assign transfer = rx_done && !rx_avail && !ovr;

	// status flags; every set except that of seen is written after its clear so the set wins
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i || !ctl1[`USC_C1_EN])
		begin
			rx_avail <= 1'b0;
			ovr <= 1'b0;
			noise <= 1'b0;
			ferr <= 1'b0;
			perr <= 1'b0;
			ridle <= 1'b1;
			tidle <= 1'b1;
			tempty <= 1'b1;
			seen <= 1'b0;
			snap_avail <= 1'b0;
			snap_tidle <= 1'b0;
			snap_tempty <= 1'b0;
			rx_data <= 8'h00;
			rx_ninth <= 1'b0;
		end
		else
		begin
			ridle <= (rx_state == USC_RX_IDLE);
			if (rd_pend && addr_q == `USC_OFF_STATUS)
			begin
				seen <= 1'b1;
				snap_avail <= rx_avail;
				snap_tidle <= tidle;
				snap_tempty <= tempty;
			end
			if ((data_rd || data_wr) && seen)
			begin
				seen <= 1'b0;
				ovr <= 1'b0;
				noise <= 1'b0;
				ferr <= 1'b0;
				perr <= 1'b0;
				if (data_rd && snap_avail)
					rx_avail <= 1'b0;
				if (data_wr && snap_tidle)
					tidle <= 1'b0;
				if (data_wr && snap_tempty)
					tempty <= 1'b0;
			end
			if (tx_load || !tx_run)
				tempty <= 1'b1;
			if (tempty && tx_state == USC_TX_IDLE && !hold_full && !data_wr && !ctl1[`USC_C1_BRK])
				tidle <= 1'b1;
			if (rx_done && (rx_avail || ovr))
				ovr <= 1'b1;
			if (transfer)
			begin
				rx_data <= rx_shift[7:0];
				rx_ninth <= rx_shift[8];
				rx_avail <= 1'b1;
				noise <= rx_nz;
				ferr <= rx_fe;
				perr <= rx_pe;
			end
		end
	end

	// pin drivers and receive event, all registered
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			tx_o <= 1'b1;
			tx_oe_o <= 1'b0;
			rx_claim_o <= 1'b0;
			rx_event_o <= 1'b0;
		end
		else
		begin
			tx_o <= tx_line;
			tx_oe_o <= tx_run;
			rx_claim_o <= rx_run;
			rx_event_o <= transfer && ctl2[`USC_C2_RIE];
		end
	end
endmodule : usc_uart
`default_nettype wire

//--- testbench/usc_uart_properties.sv
// port-level assertions of the serial block, bound to its top module
`include "usc_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module usc_uart_properties
#(
	parameter int ADDR_W = 8
)
(
	// clock and reset
	input wire logic mclk_i,
	input wire logic sys_rst_i,
	// ahb-lite slave side
	input wire logic hsel_i,
	input wire logic [ADDR_W-1:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	// serial pins
	input wire logic tx_o,
	input wire logic tx_oe_o,
	input wire logic rx_claim_o,
	input wire logic rx_event_o
);
	logic wr_pend;
	logic [7:0] wr_addr;
	logic blk_en;
	logic mode_on;
	logic tx_en;
	logic tx_allow;
	// address phase of a write, kept for its data phase
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
			wr_pend <= 1'b0;
		else if (hready_i)
			wr_pend <= hsel_i && htrans_i[1] && hwrite_i;
	end
	always_ff @(posedge mclk_i)
	begin
		if (hready_i)
			wr_addr <= haddr_i[7:0];
	end
	// shadow of the enables, so the pin driver is judged without the register bodies
	always_ff @(posedge mclk_i)
	begin
		if (sys_rst_i)
		begin
			blk_en <= 1'b0;
			mode_on <= 1'b0;
			tx_en <= 1'b0;
		end
		else if (wr_pend && hready_i)
		begin
			if (wr_addr == `USC_OFF_CTL1)
				blk_en <= hwdata_i[`USC_C1_EN];
			if (wr_addr == `USC_OFF_MODE)
				mode_on <= hwdata_i[`USC_MODE_SEL];
			if (wr_addr == `USC_OFF_CTL2)
				tx_en <= hwdata_i[`USC_C2_TXEN];
			else if (wr_addr == `USC_OFF_CTL1 && !hwdata_i[`USC_C1_EN])
				tx_en <= 1'b0;
		end
	end
	assign tx_allow = blk_en && mode_on && tx_en;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_rd_req;
		hsel_i && htrans_i[1] && hready_i && !hwrite_i;
	endsequence
	sequence s_wr_req;
		hsel_i && htrans_i[1] && hready_i && hwrite_i;
	endsequence
	property p_rd_wait;
		s_rd_req |=> !hreadyout_o ##1 hreadyout_o;
	endproperty
	property p_wr_zero;
		s_wr_req |=> hreadyout_o;
	endproperty
	property p_okay;
		hresp_o == 1'b0;
	endproperty
	property p_rst_out;
		$fell(sys_rst_i) |-> tx_o && !tx_oe_o && !rx_claim_o && !rx_event_o;
	endproperty
	property p_oe_allow;
		tx_oe_o |-> $past(tx_allow);
	endproperty
	property p_start_len;
		$fell(tx_o) && tx_oe_o |-> !tx_o [*8];
	endproperty
	property p_evt_pulse;
		rx_event_o |-> rx_claim_o ##1 !rx_event_o;
	endproperty
	property p_idle_high;
		$rose(tx_oe_o) |-> tx_o;
	endproperty
	a_rd_wait: assert property (p_rd_wait)
		else $error("read wait state wrong");
	a_wr_zero: assert property (p_wr_zero)
		else $error("write stalled");
	a_okay: assert property (p_okay)
		else $error("response not okay");
	a_rst_out: assert property (p_rst_out)
		else $error("pins wrong after reset");
	a_oe_allow: assert property (p_oe_allow)
		else $error("tx driven without enables");
	a_start_len: assert property (p_start_len)
		else $error("start bit too short");
	a_evt_pulse: assert property (p_evt_pulse)
		else $error("receive event not a pulse");
	a_idle_high: assert property (p_idle_high)
		else $error("tx not idle high when driven");
endmodule : usc_uart_properties
bind usc_uart usc_uart_properties #(.ADDR_W(ADDR_W)) u_props
(
	.mclk_i(mclk_i),
	.sys_rst_i(sys_rst_i),
	.hsel_i(hsel_i),
	.haddr_i(haddr_i),
	.htrans_i(htrans_i),
	.hwrite_i(hwrite_i),
	.hwdata_i(hwdata_i),
	.hready_i(hready_i),
	.hreadyout_o(hreadyout_o),
	.hresp_o(hresp_o),
	.tx_o(tx_o),
	.tx_oe_o(tx_oe_o),
	.rx_claim_o(rx_claim_o),
	.rx_event_o(rx_event_o)
);
`default_nettype wire

//--- testbench/usc_remote.sv
// remote serial device: sends frames to the receiver and captures transmitted frames
`timescale 1ns/100ps
`default_nettype none
module usc_remote
#(
	parameter int BIT_CLKS = 16
)
(
	// clock
	input wire logic mclk_i,
	// serial lines
	input wire logic tx_i,
	input wire logic tx_oe_i,
	output logic rx_o
);
	logic [11:0] cap = 12'h000;
	int caps = 0;
	initial rx_o = 1'b1;
	// capture twelve bits after a start edge, mid-bit, lsb first
	always
	begin
		@(posedge mclk_i);
		if (tx_oe_i === 1'b1 && tx_i === 1'b0)
		begin
			repeat (BIT_CLKS / 2) @(posedge mclk_i);
			for (int i = 0; i < 12; i++)
			begin
				repeat (BIT_CLKS) @(posedge mclk_i);
				cap[i] = tx_i;
			end
			caps++;
		end
	end
	// start bit in bits[0]; the one-clock spike sits at tick 9 of bits[1], inside samples 7..9 for a detection lag of up to one clock
	task send(input logic [12:0] bits, input logic glitch);
		for (int i = 0; i < 13; i++)
			for (int c = 0; c < BIT_CLKS; c++)
			begin
				rx_o <= bits[i] ^ (glitch && i == 1 && c == BIT_CLKS / 2 + 1);
				@(posedge mclk_i);
			end
		// the top bit is always an idle one, so the line rests high and a following send may start at once
	endtask : send
endmodule : usc_remote
`default_nettype wire

//--- testbench/tb_top.sv
// self-checking bench of the serial block against the remote device model
`include "usc_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic mclk = 1'b0;
	logic sys_rst = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [7:0] haddr = 8'h00;
	logic [1:0] htrans = 2'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hready, hresp, rx_line, tx_line, tx_oe, rx_claim, rx_event;
	logic [31:0] rd;
	logic [31:0] seed = 32'hf5c13d7b;
	logic [3:0] cfg;
	logic [8:0] dat;
	logic perr, ferr, nz;
	int mismatches = 0;
	int samples_checked = 0;
	int lowc;
	int caps0;
	// 125 MHz
	always #4 mclk = ~mclk;
	usc_uart DUT (.mclk_i(mclk), .sys_rst_i(sys_rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
		.hreadyout_o(hready), .hresp_o(hresp), .rx_i(rx_line), .tx_o(tx_line), .tx_oe_o(tx_oe),
		.rx_claim_o(rx_claim), .rx_event_o(rx_event));
	usc_remote RMT (.mclk_i(mclk), .tx_i(tx_line), .tx_oe_i(tx_oe), .rx_o(rx_line));
	task finish_test;
		if (mismatches == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// bounded wait: 0 bus ready, 1 receive event, 2 new captured frame
	task wait_on(input int which);
		int n;
		n = 0;
		@(posedge mclk);
		while ((which == 0 ? hready : which == 1 ? rx_event : RMT.caps != caps0) !== 1'b1)
		begin
			n++;
			if (n > 900)
			begin
				mismatches++;
				finish_test();
			end
			@(posedge mclk);
		end
	endtask : wait_on
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wait_on(0);
		htrans <= 2'h0;
		hwdata <= wd;
		wait_on(0);
		rd = hrdata;
	endtask : xfer
	task rdchk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : rdchk
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs
	// bits after the start bit; c is {nine bits, parity on, odd, two stops}
	function automatic logic [11:0] frame(logic [8:0] d, logic [3:0] c, logic bad_par, logic bad_stop);
		logic [11:0] f;
		int k;
		f = 12'hfff;
		k = c[3] ? 9 : 8;
		for (int i = 0; i < k; i++)
			f[i] = d[i];
		if (c[2])
		begin
			f[k] = ^(c[3] ? d : {1'b0, d[7:0]}) ^ c[1] ^ bad_par;
			k++;
		end
		f[k] = ~bad_stop;
		return f;
	endfunction : frame
	initial
	begin
		repeat (3) @(posedge mclk);
		sys_rst <= 1'b0;
		rdchk(`USC_OFF_STATUS, 32'h0b);
		rdchk(`USC_OFF_CTL1, 32'h00);
		rdchk(`USC_OFF_CTL2, 32'h00);
		rdchk(8'h18, 32'h00);
		xfer(1'b1, `USC_OFF_MODE, 32'h01);
		xfer(1'b1, `USC_OFF_CTL1, 32'h80);
		xfer(1'b1, `USC_OFF_CTL2, 32'he4);
		rdchk(`USC_OFF_STATUS, 32'h0b);
		for (int i = 0; i < 8; i++)
		begin
			seed = xs(seed);
			cfg = seed[3:0];
			dat = seed[16:8];
			perr = (i % 4 == 1) && cfg[2];
			ferr = (i % 4 == 2);
			nz = (i % 4 == 3);
			xfer(1'b1, `USC_OFF_CTL1, {24'h0, 1'b1, cfg, 2'b00, dat[8]});
			xfer(1'b0, `USC_OFF_STATUS, 32'h0);
			caps0 = RMT.caps;
			xfer(1'b1, `USC_OFF_DATA, {23'h0, dat});
			rdchk(`USC_OFF_STATUS, 32'h09);
			wait_on(2);
			chk(RMT.cap, frame(dat, cfg, 1'b0, 1'b0));
			fork
				RMT.send({frame(dat, cfg, perr, ferr), 1'b0}, nz);
				wait_on(1);
			join
			rdchk(`USC_OFF_STATUS, {24'h0, perr, nz, ferr, 5'h0f});
			rdchk(`USC_OFF_DATA, {24'h0, dat[7:0]});
			xfer(1'b0, `USC_OFF_CTL1, 32'h0);
			if (cfg[3])
				chk(rd[1], dat[8]);
			rdchk(`USC_OFF_STATUS, 32'h0b);
		end
		// second word lands while the first is unread, with a spike that must not count
		fork
			begin
				RMT.send({frame(9'h05a, cfg, 1'b0, 1'b0), 1'b0}, 1'b0);
				RMT.send({frame(9'h03c, cfg, 1'b0, 1'b0), 1'b0}, 1'b1);
			end
			wait_on(1);
		join
		rdchk(`USC_OFF_STATUS, 32'h1f);
		rdchk(`USC_OFF_DATA, 32'h5a);
		rdchk(`USC_OFF_STATUS, 32'h0b);
		// low speed: start bit of 64 clocks, up to one tick short since the prescaler runs free
		xfer(1'b1, `USC_OFF_CTL2, 32'hc4);
		xfer(1'b1, `USC_OFF_CTL1, 32'h80);
		xfer(1'b1, `USC_OFF_DATA, 32'hff);
		lowc = 0;
		repeat (700)
		begin
			@(posedge mclk);
			lowc += !tx_line;
		end
		chk(lowc >= 61 && lowc <= 64, 1);
		xfer(1'b1, `USC_OFF_CTL2, 32'he4);
		xfer(1'b1, `USC_OFF_CTL1, 32'h84);
		lowc = 0;
		repeat (300)
		begin
			@(posedge mclk);
			lowc += !tx_line;
		end
		chk(lowc >= 13 * 16, 1);
		xfer(1'b1, `USC_OFF_CTL1, 32'h00);
		rdchk(`USC_OFF_CTL2, 32'h24);
		rdchk(`USC_OFF_STATUS, 32'h0b);
		chk(tx_oe, 0);
		chk(rx_claim, 0);
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
